/* hdl/temp_limit_alarm_logic.v */
// Limit checking, status flags, alarm latch and shutdown outputs of the temperature monitor
//
// Operation
// - High flag when reading exceeds high limit
// - Low flag when reading at or below low
// - Shutdown low above limit, release below hysteresis
// - Hysteresis defaults ten, writable, serves both outputs
// - Secondary shutdown follows high limit only
// - Secondary shutdown hysteresis and automatic release
// - Status read-only; bit seven shows busy
// - High or low condition sets alarm latch in alarm mode only
// - Status read clears only vanished flags
// - Latch clears on read or ARA if gone
// - Shutdown flag self-clears within limits
// - High and low flags sticky until read
// - One-shot write converts once in standby
// - Fault field selects one to four results
// - Mask bit silences alarm in alarm mode
// - Config bit five selects pin function
// - Standby stops conversions, outputs stay active
`timescale 1ns/1ps
`include "temp_limit_consts.vh"
module temp_limit_alarm_logic
#(
  parameter [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter [7:0] REVISION_CODE = 8'h01 // Arbitrary value
)
(
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Register access from the serial engine
  input wire regWrStb,
  input wire regRdStb,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData_ff,
  input wire araAnswered,
  // Converter
  input wire convDone,
  input wire [7:0] convResult,
  output reg convStart_ff,
  output reg convBusy_ff,
  // Pins, active low
  output reg overtempShutdownOut_b_ff,
  output reg multiPinOut_b_ff,
  // Settings for surrounding logic
  output reg [3:0] rateCode_ff,
  output reg rangeExt_ff,
  output reg busTimeoutEn_ff
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] tempReading_ff;
  reg [7:0] config_ff;
  reg [7:0] highLimit_ff;
  reg [7:0] lowLimit_ff;
  reg [7:0] shdnLimit_ff;
  reg [7:0] hyst_ff;
  reg [7:0] faultCfg_ff;
  reg [7:0] convRate_ff;
  reg highFlag_ff;
  reg lowFlag_ff;
  reg shdnFlag_ff;
  reg secShdn_ff;
  reg alarmLatch_ff;
  reg evalStb_ff;
  reg oneShotRun_ff;
  reg limitWr_ff;
  reg [15:0] convCnt_ff;
  reg [15:0] nxt_convCnt;
  reg [7:0] nxt_rdData;
  wire runMet;

  wire standby = config_ff[`CFG_STANDBY_BIT];
  wire pinIsSecond = config_ff[`CFG_PINSEL_BIT];
  wire alarmMasked = config_ff[`CFG_MASK_BIT];
  wire statusRead = regRdStb && (regAddr == `RA_STATUS);
  wire limitWrite = regWrStb && ((regAddr == `WA_HIGH) || (regAddr == `WA_LOW) ||
    (regAddr == `WA_SHDN) || (regAddr == `WA_HYST) || (regAddr == `WA_CONFIG));
  wire oneShotWr = regWrStb && (regAddr == `WA_ONESHOT);

  // ----------------------------------------
  // Live comparisons on the stored reading
  // ----------------------------------------
  wire overHigh = tempReading_ff > highLimit_ff;
  wire atOrBelowLow = tempReading_ff <= lowLimit_ff;
  wire overShdn = tempReading_ff > shdnLimit_ff;
  // Saturating subtraction avoids wrap when hysteresis exceeds limit
  wire [7:0] shdnRel = (shdnLimit_ff > hyst_ff) ? shdnLimit_ff - hyst_ff : 8'h00;
  wire [7:0] highRel = (highLimit_ff > hyst_ff) ? highLimit_ff - hyst_ff : 8'h00;
  wire belowShdnRel = tempReading_ff <= shdnRel;
  wire belowHighRel = tempReading_ff <= highRel;
  wire alarmCause = overHigh || atOrBelowLow;

  // Alarm waits for an unbroken run of out-of-limit results
  fault_run_filter runFilter
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .evalStb(evalStb_ff),
    .outOfLimit(alarmCause),
    .faultCode(faultCfg_ff[3:1]),
    .runMet_ff(runMet)
  );

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  always @*
  begin
    nxt_convCnt = convCnt_ff;
    if (convBusy_ff)
    begin
      if (convDone)
        nxt_convCnt = 16'h0000;
    end
    else if (convCnt_ff != 16'h0000)
      nxt_convCnt = convCnt_ff - 16'h0001;
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      convBusy_ff <= 1'b0;
      convStart_ff <= 1'b0;
      convCnt_ff <= 16'h0000;
      tempReading_ff <= `RST_TEMP;
      evalStb_ff <= 1'b0;
      oneShotRun_ff <= 1'b0;
    end
    else
    begin
      convStart_ff <= 1'b0;
      evalStb_ff <= 1'b0;
      convCnt_ff <= nxt_convCnt;
      if (convBusy_ff)
      begin
        if (convDone)
        begin
          convBusy_ff <= 1'b0;
          oneShotRun_ff <= 1'b0;
          tempReading_ff <= convResult;
          evalStb_ff <= 1'b1;
          convCnt_ff <= `CONV_CYCLES;
        end
        // Standby drops a free-running conversion unwritten; a one-shot finishes
        else if (standby && !oneShotRun_ff)
        begin
          convBusy_ff <= 1'b0;
          convCnt_ff <= 16'h0000;
        end
      end
      else if ((!standby && convCnt_ff == 16'h0000) || oneShotWr)
      begin
        convBusy_ff <= 1'b1;
        convStart_ff <= 1'b1;
        oneShotRun_ff <= oneShotWr;
      end
      else if (limitWrite)
        evalStb_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      config_ff <= `RST_CONFIG;
      convRate_ff <= `RST_RATE;
      highLimit_ff <= `RST_HIGH;
      lowLimit_ff <= `RST_LOW;
      shdnLimit_ff <= `RST_SHDN;
      hyst_ff <= `RST_HYST;
      faultCfg_ff <= `RST_FAULT;
    end
    else if (regWrStb)
    begin
      // One-shot data is dropped: no case stores it
      // Reserved configuration bits and upper rate nibble read back as zero
      case (regAddr)
        `WA_CONFIG: config_ff <= regWrData & `CFG_WR_MASK;
        `WA_RATE: convRate_ff <= regWrData & `RATE_WR_MASK;
        `WA_HIGH: highLimit_ff <= regWrData;
        `WA_LOW: lowLimit_ff <= regWrData;
        `WA_SHDN: shdnLimit_ff <= regWrData;
        `WA_HYST: hyst_ff <= regWrData;
        `WA_FAULT: faultCfg_ff <= regWrData;
        default: config_ff <= config_ff;
      endcase
    end
  end

  // ----------------------------------------
  // Flags, alarm latch and outputs
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      highFlag_ff <= 1'b0;
      lowFlag_ff <= 1'b0;
      shdnFlag_ff <= 1'b0;
      secShdn_ff <= 1'b0;
      alarmLatch_ff <= 1'b0;
      overtempShutdownOut_b_ff <= 1'b1;
      multiPinOut_b_ff <= 1'b1;
    end
    else
    begin
      // Set wins over a coincident status-read clear
      if (evalStb_ff && overHigh)
        highFlag_ff <= 1'b1;
      else if (statusRead && !overHigh)
        highFlag_ff <= 1'b0;
      if (evalStb_ff && atOrBelowLow)
        lowFlag_ff <= 1'b1;
      else if (statusRead && !atOrBelowLow)
        lowFlag_ff <= 1'b0;
      // Shutdown paths re-evaluate on conversions and, one edge late, limit writes
      if (evalStb_ff || limitWr_ff)
      begin
        if (overShdn)
          shdnFlag_ff <= 1'b1;
        else if (belowShdnRel)
          shdnFlag_ff <= 1'b0;
        if (overHigh)
          secShdn_ff <= 1'b1;
        else if (belowHighRel)
          secShdn_ff <= 1'b0;
      end
      if (runMet && !pinIsSecond)
        alarmLatch_ff <= 1'b1;
      else if ((statusRead || araAnswered) && !alarmCause)
        alarmLatch_ff <= 1'b0;
      overtempShutdownOut_b_ff <= !shdnFlag_ff;
      if (pinIsSecond)
        multiPinOut_b_ff <= !secShdn_ff;
      else
        multiPinOut_b_ff <= !(alarmLatch_ff && !alarmMasked);
    end
  end

  // ----------------------------------------
  // Limit-write re-evaluation delay
  // ----------------------------------------
  // New limits land at the write edge; comparing then would still see the old ones
  always @(posedge mclk)
  begin
    if (!rst_b)
      limitWr_ff <= 1'b0;
    else
      limitWr_ff <= limitWrite;
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    case (regAddr)
      `RA_TEMP: nxt_rdData = tempReading_ff;
      `RA_STATUS: nxt_rdData = {convBusy_ff, highFlag_ff, lowFlag_ff, 4'h0, shdnFlag_ff};
      `RA_CONFIG: nxt_rdData = config_ff;
      `RA_RATE: nxt_rdData = convRate_ff;
      `RA_HIGH: nxt_rdData = highLimit_ff;
      `RA_LOW: nxt_rdData = lowLimit_ff;
      `RA_SHDN: nxt_rdData = shdnLimit_ff;
      `RA_HYST: nxt_rdData = hyst_ff;
      `RA_FAULT: nxt_rdData = faultCfg_ff;
      `RA_MAKER: nxt_rdData = MAKER_CODE;
      `RA_REV: nxt_rdData = REVISION_CODE;
      default: nxt_rdData = 8'h00;
    endcase
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      regRdData_ff <= 8'h00;
      rateCode_ff <= 4'h8;
      rangeExt_ff <= 1'b0;
      busTimeoutEn_ff <= 1'b0;
    end
    else
    begin
      if (regRdStb)
        regRdData_ff <= nxt_rdData;
      rateCode_ff <= convRate_ff[3:0];
      rangeExt_ff <= config_ff[`CFG_RANGE_BIT];
      busTimeoutEn_ff <= faultCfg_ff[`FLT_TIMEOUT_BIT];
    end
  end

endmodule // temp_limit_alarm_logic

/* hdl/temp_limit_consts.vh */
// Register offsets, field positions, reset values and timing of the limit and alarm logic
`ifndef TEMP_LIMIT_CONSTS_VH
`define TEMP_LIMIT_CONSTS_VH

// ----------------------------------------
// Read addresses
// ----------------------------------------
`define RA_TEMP 8'h00
`define RA_STATUS 8'h02
`define RA_CONFIG 8'h03
`define RA_RATE 8'h04
`define RA_HIGH 8'h05
`define RA_LOW 8'h06
`define RA_SHDN 8'h20
`define RA_HYST 8'h21
`define RA_FAULT 8'h22
`define RA_MAKER 8'hfe
`define RA_REV 8'hff

// ----------------------------------------
// Write addresses
// ----------------------------------------
`define WA_CONFIG 8'h09
`define WA_RATE 8'h0a
`define WA_HIGH 8'h0b
`define WA_LOW 8'h0c
`define WA_ONESHOT 8'h0f
`define WA_SHDN 8'h20
`define WA_HYST 8'h21
`define WA_FAULT 8'h22

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_TEMP 8'h00
`define RST_CONFIG 8'h00
`define RST_RATE 8'h08
`define RST_HIGH 8'h55
`define RST_LOW 8'h00
`define RST_SHDN 8'h55
`define RST_HYST 8'h0a
`define RST_FAULT 8'h01

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_MASK_BIT 7
`define CFG_STANDBY_BIT 6
`define CFG_PINSEL_BIT 5
`define CFG_RANGE_BIT 2
`define ST_BUSY_BIT 7
`define ST_HIGH_BIT 6
`define ST_LOW_BIT 5
`define ST_SHDN_BIT 0
`define FLT_TIMEOUT_BIT 7
`define CFG_WR_MASK 8'he4
`define RATE_WR_MASK 8'h0f

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define CONV_TIME_NS 1000
// Idle cycles between conversions, CONV_TIME_NS / CLK_PERIOD_NS at counter width
`define CONV_CYCLES 16'h0032

`endif

/* hdl/fault_run_filter.v */
// Consecutive out-of-limit run counter gating the alarm latch
`timescale 1ns/1ps
module fault_run_filter
(
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Evaluation strobe and result
  input wire evalStb,
  input wire outOfLimit,
  input wire [2:0] faultCode,
  // Run long enough
  output reg runMet_ff
);

  reg [2:0] runCnt_ff;
  reg [2:0] nxt_runCnt;
  reg [2:0] needed;

  // Thermometer codes; other codes fall back to one
  always @*
  begin
    case (faultCode)
      3'b001: needed = 3'd2;
      3'b011: needed = 3'd3;
      3'b111: needed = 3'd4;
      default: needed = 3'd1;
    endcase
  end

  always @*
  begin
    nxt_runCnt = runCnt_ff;
    if (evalStb)
    begin
      if (!outOfLimit)
        nxt_runCnt = 3'd0;
      else if (runCnt_ff < 3'd4)
        nxt_runCnt = runCnt_ff + 3'd1;
    end
  end

  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      runCnt_ff <= 3'd0;
      runMet_ff <= 1'b0;
    end
    else
    begin
      runCnt_ff <= nxt_runCnt;
      runMet_ff <= evalStb && outOfLimit && (nxt_runCnt >= needed);
    end
  end

endmodule // fault_run_filter

/* test/adc_model.sv */
// Converter stand-in answering each start pulse after a fixed latency
`timescale 1ns/1ps
module adc_model
#(
  parameter LAT = 5
)
(
  // Clock and request
  input wire mclk,
  input wire startReq,
  input wire [7:0] tempNow,
  // Result
  output reg doneStb,
  output reg [7:0] result
);
  integer cnt = 0;
  initial
  begin
    doneStb = 1'b0;
    result = 8'h00;
  end
  // Result bus is not held outside the done pulse
  always @(posedge mclk)
  begin
    doneStb <= (cnt == 1);
    result <= (cnt == 1) ? tempNow : ~tempNow;
    cnt <= startReq ? LAT : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule // adc_model

/* test/temp_limit_alarm_logic_sva.sv */
// Assertion checker for the limit and alarm logic
`timescale 1ns/1ps
module temp_limit_alarm_logic_sva
(
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Register bus
  input wire regWrStb,
  input wire regRdStb,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData_ff,
  // Converter and pins
  input wire convDone,
  input wire convStart_ff,
  input wire convBusy_ff,
  input wire multiPinOut_b_ff,
  input wire busTimeoutEn_ff
);
  reg [7:0] cfg_ff;
  wire osWr = regWrStb && regAddr == 8'h0f;
  wire stby = cfg_ff[6];
  wire masked = cfg_ff[7] && !cfg_ff[5];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Shadow of the configuration, since standby and mask are not on the ports
  always @(posedge mclk)
  begin
    if (!rst_b)
      cfg_ff <= 8'h00;
    else if (regWrStb && regAddr == 8'h09)
      cfg_ff <= regWrData;
  end
  AST_BUSY_SET: assert property (convStart_ff |-> convBusy_ff)
    else $error("busy missing at start");
  AST_BUSY_END: assert property (convBusy_ff && convDone |=> !convBusy_ff)
    else $error("busy held after done");
  AST_START_PULSE: assert property (convStart_ff |=> !convStart_ff)
    else $error("start pulse too long");
  AST_TIMEOUT_BIT: assert property (
    regWrStb && regAddr == 8'h22 |-> ##2 busTimeoutEn_ff == $past(regWrData[7], 2))
    else $error("timeout enable not updated");
  AST_STATUS_BUSY: assert property (
    regRdStb && regAddr == 8'h02 |=> regRdData_ff[7] == $past(convBusy_ff))
    else $error("status busy bit wrong");
  AST_ONESHOT: assert property (
    osWr && stby && !convBusy_ff |-> ##[1:2] convStart_ff)
    else $error("one-shot did not start");
  AST_STANDBY: assert property (
    stby && $past(stby) && !convBusy_ff && !osWr && !$past(osWr) |=> !convStart_ff)
    else $error("conversion started in standby");
  AST_MASK: assert property (masked && $past(masked) |-> multiPinOut_b_ff)
    else $error("masked alarm asserted");
  cover property (osWr && stby);
  cover property (!multiPinOut_b_ff);
  cover property (convBusy_ff && convDone);
endmodule // temp_limit_alarm_logic_sva
bind temp_limit_alarm_logic temp_limit_alarm_logic_sva chk (.mclk, .rst_b, .regWrStb,
  .regRdStb, .regAddr, .regWrData, .regRdData_ff, .convDone, .convStart_ff, .convBusy_ff,
  .multiPinOut_b_ff, .busTimeoutEn_ff);

/* test/temp_limit_alarm_logic_test.sv */
// Self-checking testbench of the limit and alarm logic
`timescale 1ns/1ps
module temp_limit_alarm_logic_test;
  reg mclk;
  reg rst_b;
  reg regWrStb;
  reg regRdStb;
  reg [7:0] regAddr;
  reg [7:0] regWrData;
  reg araAnswered;
  reg [7:0] tempNow;
  reg [7:0] q;
  wire convDone;
  wire [7:0] convResult;
  wire convStart_ff;
  wire convBusy_ff;
  wire [7:0] regRdData_ff;
  wire shdnOut_b;
  wire multiOut_b;
  wire [3:0] rateCode;
  wire rangeExt;
  wire busTimeout;
  integer failures = 0;
  integer n_compared = 0;
  integer cycles = 0;
  integer i;
  integer k;
  temp_limit_alarm_logic uut (.mclk(mclk), .rst_b(rst_b), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData_ff(regRdData_ff), .araAnswered(araAnswered), .convDone(convDone),
    .convResult(convResult), .convStart_ff(convStart_ff), .convBusy_ff(convBusy_ff),
    .overtempShutdownOut_b_ff(shdnOut_b), .multiPinOut_b_ff(multiOut_b),
    .rateCode_ff(rateCode), .rangeExt_ff(rangeExt), .busTimeoutEn_ff(busTimeout));
  adc_model adc (.mclk(mclk), .startReq(convStart_ff), .tempNow(tempNow),
    .doneStb(convDone), .result(convResult));
  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      complete_run;
    end
  end
  task complete_run;
  begin
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task pin(input [63:0] nm, input e, input g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrStb <= 1'b0;
    @(posedge mclk);
  end
  endtask
  task rdc(input [7:0] a, input [7:0] e, input [63:0] nm);
  begin
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRdStb <= 1'b0;
    @(posedge mclk);
    chk(nm, e, regRdData_ff);
  end
  endtask
  // Standby is set, so each result comes from one one-shot write
  task conv(input [7:0] t);
  begin
    tempNow <= t;
    wr(8'h0f, 8'h00);
    k = 0;
    while (!convDone && k < 40)
    begin
      @(posedge mclk);
      k = k + 1;
    end
    repeat (4) @(posedge mclk);
  end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
  begin
    rdc(8'h03, 8'h00, "config");
    rdc(8'h04, 8'h08, "rate");
    rdc(8'h05, 8'h55, "high");
    rdc(8'h06, 8'h00, "low");
    rdc(8'h20, 8'h55, "shdn");
    rdc(8'h21, 8'h0a, "hyst");
    rdc(8'h22, 8'h01, "fault");
    rdc(8'h01, 8'h00, "spare");
  end
  endtask
  task t_busy;
  begin
    wr(8'h0f, 8'h00);
    rdc(8'h02, 8'h80, "status");
    repeat (10) @(posedge mclk);
    wr(8'h02, 8'hff);
    rdc(8'h02, 8'h00, "status");
  end
  endtask
  task t_alarm;
  begin
    conv(8'h55);
    rdc(8'h02, 8'h00, "status");
    conv(8'h56);
    pin("alarm", 1'b0, multiOut_b);
    rdc(8'h02, 8'h41, "status");
    conv(8'h20);
    rdc(8'h02, 8'h40, "status");
    rdc(8'h02, 8'h00, "status");
    repeat (3) @(posedge mclk);
    pin("alarm", 1'b1, multiOut_b);
    wr(8'h0c, 8'h10);
    conv(8'h10);
    rdc(8'h02, 8'h20, "status");
    conv(8'h20);
    rdc(8'h02, 8'h20, "status");
    rdc(8'h02, 8'h00, "status");
  end
  endtask
  task t_shdn;
  begin
    conv(8'h56);
    pin("shdn", 1'b0, shdnOut_b);
    conv(8'h4c);
    pin("shdn", 1'b0, shdnOut_b);
    conv(8'h4b);
    pin("shdn", 1'b1, shdnOut_b);
    rdc(8'h02, 8'h40, "status");
    wr(8'h21, 8'h05);
    conv(8'h56);
    conv(8'h50);
    pin("shdn", 1'b1, shdnOut_b);
    rdc(8'h02, 8'h40, "status");
  end
  endtask
  task t_fault;
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h22, (8'h02 << i) - 8'h02);
      repeat (i) conv(8'h60);
      conv(8'h20);
      repeat (i) conv(8'h60);
      pin("alarm", 1'b1, multiOut_b);
      conv(8'h60);
      pin("alarm", 1'b0, multiOut_b);
      conv(8'h20);
      rdc(8'h02, 8'h40, "status");
    end
    wr(8'h22, 8'h80);
    rdc(8'h22, 8'h80, "fault");
    pin("timeout", 1'b1, busTimeout);
  end
  endtask
  task t_second;
  begin
    wr(8'h09, 8'h60);
    conv(8'h56);
    pin("second", 1'b0, multiOut_b);
    conv(8'h4b);
    pin("second", 1'b1, multiOut_b);
    conv(8'h05);
    pin("second", 1'b1, multiOut_b);
    conv(8'h20);
    rdc(8'h02, 8'h60, "status");
    wr(8'h09, 8'h40);
  end
  endtask
  task t_mask;
  begin
    wr(8'h09, 8'hc0);
    conv(8'h56);
    pin("alarm", 1'b1, multiOut_b);
    wr(8'h09, 8'h40);
    repeat (3) @(posedge mclk);
    pin("alarm", 1'b0, multiOut_b);
  end
  endtask
  task t_ara;
  begin
    conv(8'h20);
    araAnswered <= 1'b1;
    @(posedge mclk);
    araAnswered <= 1'b0;
    repeat (3) @(posedge mclk);
    pin("alarm", 1'b1, multiOut_b);
  end
  endtask
  // Range switch with limits reprogrammed by the host, then live limit writes
  task t_range;
  begin
    wr(8'h0a, 8'hfc);
    rdc(8'h04, 8'h0c, "rate");
    chk("ratecode", 8'h0c, {4'h0, rateCode});
    wr(8'h09, 8'h5f);
    wr(8'h0b, 8'h95);
    pin("range", 1'b1, rangeExt);
    rdc(8'h03, 8'h44, "config");
    wr(8'h20, 8'h10);
    repeat (3) @(posedge mclk);
    pin("shdn", 1'b0, shdnOut_b);
    wr(8'h20, 8'h55);
    repeat (3) @(posedge mclk);
    pin("shdn", 1'b1, shdnOut_b);
  end
  endtask
  initial
  begin
    rst_b = 1'b0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    araAnswered = 1'b0;
    tempNow = 8'h20;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset;
    wr(8'h09, 8'h40);
    repeat (10) @(posedge mclk);
    t_busy;
    t_alarm;
    t_shdn;
    t_fault;
    t_second;
    t_mask;
    t_ara;
    t_range;
    complete_run;
  end
endmodule // temp_limit_alarm_logic_test
